/* rtl/pwg_access_guard.sv */
// AXI4-Lite register block of the peripheral write guard with two protect groups.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pwg_cfg.svh"

module pwg_access_guard (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic [`PWG_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`PWG_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Peripheral write gating, one bit per slot position
    input  wire logic [7:0]              periph_wr_req_g0,
    input  wire logic [7:0]              periph_wr_req_g1,
    output var  logic [7:0]              periph_wr_grant_g0,
    output var  logic [7:0]              periph_wr_grant_g1,
    output var  logic                    periph_wr_err_g0,
    output var  logic                    periph_wr_err_g1,
    // Per-slot protect levels
    output var  pwg_pkg::pwg_grp0_s      grp0_protect,
    output var  pwg_pkg::pwg_grp1_s      grp1_protect,
    // Interrupt
    output var  logic                    irq
);
    import pwg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    logic                 wr_fire;
    logic                 rd_fire;
    pwg_reg_e             wr_sel;
    pwg_reg_e             rd_sel;
    logic [31:0]          wr_bits;
    logic [7:0]           g0_prot;
    logic [7:0]           g1_prot;
    logic                 g0_dbl_set;
    logic                 g0_dbl_clr;
    logic                 g1_dbl_set;
    logic                 g1_dbl_clr;
    logic                 dbl_any;
    logic [1:0]           bresp_next;
    logic                 bvalid_reg;
    logic                 bvalid_next;
    logic [1:0]           bresp_reg;
    logic                 rvalid_reg;
    logic                 rvalid_next;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;
    logic [1:0]           rresp_reg;
    logic [1:0]           rresp_next;
    logic [`PWG_EV_W-1:0] stat_reg;
    logic [`PWG_EV_W-1:0] stat_next;
    logic [`PWG_EV_W-1:0] mask_reg;
    logic [`PWG_EV_W-1:0] mask_next;
    logic [`PWG_EV_W-1:0] events;
    logic [`PWG_EV_W-1:0] stat_w1c;

    logic                 wr_g0_clr;
    logic                 wr_g0_set;
    logic                 wr_g1_clr;
    logic                 wr_g1_set;
    logic                 rd_g0;
    logic                 rd_g1;
    logic [31:0]          lane_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel. Address and data are taken together in one beat, so a master
    // that offers them in either order simply waits until both stand.

    assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign wr_sel        = pwg_decode(s_axi_awaddr);
    assign lane_mask     = pwg_lane_mask(s_axi_wstrb);
    assign wr_bits       = s_axi_wdata & lane_mask;

    // Register write strobes.
    assign wr_g0_clr     = wr_fire && (wr_sel == PWG_REG_G0_CLR);
    assign wr_g0_set     = wr_fire && (wr_sel == PWG_REG_G0_SET);
    assign wr_g1_clr     = wr_fire && (wr_sel == PWG_REG_G1_CLR);
    assign wr_g1_set     = wr_fire && (wr_sel == PWG_REG_G1_SET);

    pwg_protect_group #(
        .RESET_VAL  (`PWG_G0_RESET),
        .VALID_MASK (`PWG_G0_VALID)
    ) u_group0 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr_hit  (wr_g0_clr),
        .set_hit  (wr_g0_set),
        .wr_bits  (wr_bits[7:0]),
        .prot_reg (g0_prot),
        .dbl_set  (g0_dbl_set),
        .dbl_clr  (g0_dbl_clr)
    );

    pwg_protect_group #(
        .RESET_VAL  (`PWG_G1_RESET),
        .VALID_MASK (`PWG_G1_VALID)
    ) u_group1 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr_hit  (wr_g1_clr),
        .set_hit  (wr_g1_set),
        .wr_bits  (wr_bits[7:0]),
        .prot_reg (g1_prot),
        .dbl_set  (g1_dbl_set),
        .dbl_clr  (g1_dbl_clr)
    );

    // The well-formed bits of a misuse write still take effect; only the answer and the
    // status bits report the misuse, which keeps the state machine-free and predictable.
    assign dbl_any    = g0_dbl_set | g0_dbl_clr | g1_dbl_set | g1_dbl_clr;
    assign bresp_next = (wr_sel == PWG_REG_NONE) ? `PWG_RESP_DECERR :
                        dbl_any                  ? `PWG_RESP_SLVERR :
                        `PWG_RESP_OKAY;
    assign bvalid_next = wr_fire ? 1'b1 : (s_axi_bready ? 1'b0 : bvalid_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `PWG_RESP_OKAY;
        end else begin
            bvalid_reg <= bvalid_next;
            bresp_reg  <= wr_fire ? bresp_next : bresp_reg;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel.

    assign s_axi_arready = ~rvalid_reg;
    assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
    assign rd_sel        = pwg_decode(s_axi_araddr);
    assign rd_g0         = (rd_sel == PWG_REG_G0_CLR) || (rd_sel == PWG_REG_G0_SET);
    assign rd_g1         = (rd_sel == PWG_REG_G1_CLR) || (rd_sel == PWG_REG_G1_SET);

    assign rdata_next    = rd_g0 ?
                               {24'h000000, g0_prot} :
                           rd_g1 ?
                               {24'h000000, g1_prot} :
                           (rd_sel == PWG_REG_STAT) ? {29'h00000000, stat_reg} :
                           (rd_sel == PWG_REG_MASK) ? {29'h00000000, mask_reg} :
                           32'h00000000;
    assign rresp_next    = (rd_sel == PWG_REG_NONE) ? `PWG_RESP_DECERR : `PWG_RESP_OKAY;
    assign rvalid_next   = rd_fire ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `PWG_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rd_fire ? rdata_next : rdata_reg;
            rresp_reg  <= rd_fire ? rresp_next : rresp_reg;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral write gating.

    pwg_write_gate u_gate0 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .protect    (g0_prot),
        .wr_req     (periph_wr_req_g0),
        .wr_grant   (periph_wr_grant_g0),
        .wr_err_reg (periph_wr_err_g0)
    );

    pwg_write_gate u_gate1 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .protect    (g1_prot),
        .wr_req     (periph_wr_req_g1),
        .wr_grant   (periph_wr_grant_g1),
        .wr_err_reg (periph_wr_err_g1)
    );

    assign grp0_protect = '{ext_irq_ctrl_slot      : g0_prot[`PWG_G0_EXTIRQ_BIT],
                            real_time_counter_slot : g0_prot[`PWG_G0_RTC_BIT],
                            watchdog_slot          : g0_prot[`PWG_G0_WDOG_BIT],
                            generic_clock_slot     : g0_prot[`PWG_G0_GENERIC_CLOCK_SLOT_BIT],
                            system_control_slot    : g0_prot[`PWG_G0_SYSCTL_BIT],
                            power_manager_slot     : g0_prot[`PWG_G0_PM_BIT]};
    assign grp1_protect = '{trace_buffer_slot      : g1_prot[`PWG_G1_TRACE_BIT],
                            io_port_slot           : g1_prot[`PWG_G1_PORT_BIT],
                            nonvolatile_ctrl_slot  : g1_prot[`PWG_G1_NVM_BIT],
                            debug_unit_slot        : g1_prot[`PWG_G1_DEBUG_BIT]};

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask. A new event beats a write-one-to-clear in the
    // same cycle so that no misuse can slip by unseen.

    assign events[`PWG_EV_DBL_SET] = g0_dbl_set | g1_dbl_set;
    assign events[`PWG_EV_DBL_CLR] = g0_dbl_clr | g1_dbl_clr;
    assign events[`PWG_EV_BLOCKED] = periph_wr_err_g0 | periph_wr_err_g1;
    assign stat_w1c  = (wr_fire && (wr_sel == PWG_REG_STAT)) ? wr_bits[`PWG_EV_W-1:0]
                                                              : {`PWG_EV_W{1'b0}};
    assign stat_next = (stat_reg & ~stat_w1c) | events;
    assign mask_next = (wr_fire && (wr_sel == PWG_REG_MASK))
                       ? ((mask_reg & ~lane_mask[`PWG_EV_W-1:0])
                          | wr_bits[`PWG_EV_W-1:0])
                       : mask_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= `PWG_STAT_RESET;
            mask_reg <= `PWG_MASK_RESET;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    reset_values_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> (g0_prot == 8'h00) && (g1_prot == 8'h02))
        else $error("Protect groups left reset with wrong values.");

    clear_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && (wr_sel == PWG_REG_G0_CLR) |=>
            (g0_prot & $past(wr_bits[7:0])) == 8'h00)
        else $error("A one written to the clear view left protection on.");

    set_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && (wr_sel == PWG_REG_G1_SET) |=>
            (g1_prot & $past(wr_bits[7:0]) & `PWG_G1_VALID)
            == ($past(wr_bits[7:0]) & `PWG_G1_VALID))
        else $error("A one written to the set view did not protect.");

    zero_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && (wr_sel == PWG_REG_G0_SET) |=>
            (g0_prot & ~$past(wr_bits[7:0])) == ($past(g0_prot) & ~$past(wr_bits[7:0])))
        else $error("A zero written to the set view changed protection.");

    lane_guard_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !s_axi_wstrb[0] |=> $stable(g0_prot) && $stable(g1_prot))
        else $error("A write without the low byte lane changed protection.");

    views_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && ((rd_sel == PWG_REG_G0_CLR) || (rd_sel == PWG_REG_G0_SET)) |=>
            s_axi_rvalid && (s_axi_rdata == {24'h000000, $past(g0_prot)}))
        else $error("Clear and set views returned different data.");

    double_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && dbl_any |=> s_axi_bvalid && (s_axi_bresp == `PWG_RESP_SLVERR))
        else $error("Double protect or unprotect answered without an error.");

    unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((g0_prot & ~`PWG_G0_VALID) == 8'h00) && ((g1_prot & ~`PWG_G1_VALID) == 8'h00))
        else $error("An unused protect bit became set.");

    slot_output_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && (wr_sel == PWG_REG_G1_CLR) && wr_bits[`PWG_G1_DEBUG_BIT] |=>
            !grp1_protect.debug_unit_slot)
        else $error("Debug slot output did not follow the clear write.");

    g1_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_g1_clr |=>
            (g1_prot & $past(wr_bits[7:0])) == 8'h00)
        else $error("Clear write left protection on.");

    g0_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_g0_set |=> (g0_prot & $past(wr_bits[7:0]) & `PWG_G0_VALID)
            == ($past(wr_bits[7:0]) & `PWG_G0_VALID))
        else $error("Set write did not protect.");

    g1_views_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_g1 |=>
            s_axi_rvalid && (s_axi_rdata == {24'h000000, $past(g1_prot)}))
        else $error("Group one views disagree.");

    blocked_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        periph_wr_err_g0 || periph_wr_err_g1 |=>
            stat_reg[`PWG_EV_BLOCKED])
        else $error("Blocked write not flagged.");

    unused_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_g0_set && ((wr_bits[7:0] & `PWG_G0_VALID & g0_prot) == 8'h00) |=>
            s_axi_bresp == `PWG_RESP_OKAY)
        else $error("Unused bits raised an error.");

    watchdog_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_g0_set && wr_bits[`PWG_G0_WDOG_BIT] |=>
            grp0_protect.watchdog_slot)
        else $error("Watchdog slot missed the set.");

endmodule : pwg_access_guard

`default_nettype wire

/* rtl/pwg_cfg.svh */
// Offsets, field positions, reset values and response codes of the peripheral write guard.
`ifndef PWG_CFG_SVH
`define PWG_CFG_SVH

`define PWG_ADDR_W        12
`define PWG_G0_BASE       12'h000
`define PWG_G1_BASE       12'h100
`define PWG_CLR_OFF       12'h000
`define PWG_SET_OFF       12'h004
`define PWG_STAT_ADDR     12'h200
`define PWG_MASK_ADDR     12'h204

`define PWG_G0_RESET      8'h00
`define PWG_G1_RESET      8'h02
`define PWG_G0_VALID      8'h7E
`define PWG_G1_VALID      8'h4E

`define PWG_G0_PM_BIT     1
`define PWG_G0_SYSCTL_BIT 2
`define PWG_G0_GENERIC_CLOCK_SLOT_BIT   3
`define PWG_G0_WDOG_BIT   4
`define PWG_G0_RTC_BIT    5
`define PWG_G0_EXTIRQ_BIT 6
`define PWG_G1_DEBUG_BIT  1
`define PWG_G1_NVM_BIT    2
`define PWG_G1_PORT_BIT   3
`define PWG_G1_TRACE_BIT  6

`define PWG_EV_W          3
`define PWG_EV_DBL_SET    0
`define PWG_EV_DBL_CLR    1
`define PWG_EV_BLOCKED    2
`define PWG_STAT_RESET    3'h0
`define PWG_MASK_RESET    3'h0

`define PWG_RESP_OKAY     2'h0
`define PWG_RESP_SLVERR   2'h2
`define PWG_RESP_DECERR   2'h3

`endif

/* rtl/pwg_none.sv */
// This file holds no logic.

/* rtl/pwg_pkg.sv */
// Types and shared decode functions of the peripheral write guard.
`include "pwg_cfg.svh"

package pwg_pkg;

    typedef enum logic [2:0] {
        PWG_REG_G0_CLR = 3'b000,
        PWG_REG_G0_SET = 3'b001,
        PWG_REG_G1_CLR = 3'b010,
        PWG_REG_G1_SET = 3'b011,
        PWG_REG_STAT   = 3'b100,
        PWG_REG_MASK   = 3'b101,
        PWG_REG_NONE   = 3'b110
    } pwg_reg_e;

    // Protect levels of the first group, bit 6 down to bit 1.
    typedef struct packed {
        logic ext_irq_ctrl_slot;
        logic real_time_counter_slot;
        logic watchdog_slot;
        logic generic_clock_slot;
        logic system_control_slot;
        logic power_manager_slot;
    } pwg_grp0_s;

    // Protect levels of the second group.
    typedef struct packed {
        logic trace_buffer_slot;
        logic io_port_slot;
        logic nonvolatile_ctrl_slot;
        logic debug_unit_slot;
    } pwg_grp1_s;

    function automatic pwg_reg_e pwg_decode(input logic [`PWG_ADDR_W-1:0] addr);
        pwg_reg_e sel;
        sel = PWG_REG_NONE;
        if (addr == (`PWG_G0_BASE | `PWG_CLR_OFF)) begin
            sel = PWG_REG_G0_CLR;
        end else if (addr == (`PWG_G0_BASE | `PWG_SET_OFF)) begin
            sel = PWG_REG_G0_SET;
        end else if (addr == (`PWG_G1_BASE | `PWG_CLR_OFF)) begin
            sel = PWG_REG_G1_CLR;
        end else if (addr == (`PWG_G1_BASE | `PWG_SET_OFF)) begin
            sel = PWG_REG_G1_SET;
        end else if (addr == `PWG_STAT_ADDR) begin
            sel = PWG_REG_STAT;
        end else if (addr == `PWG_MASK_ADDR) begin
            sel = PWG_REG_MASK;
        end
        return sel;
    endfunction : pwg_decode

    function automatic logic [31:0] pwg_lane_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : pwg_lane_mask

endpackage : pwg_pkg

/* rtl/pwg_protect_group.sv */
// One group of protect bits reached through a clear view and a set view.
`timescale 1ns/100ps
`default_nettype none

module pwg_protect_group #(
    parameter logic [7:0] RESET_VAL  = 8'h00,
    parameter logic [7:0] VALID_MASK = 8'hFF
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Write strobes and lane-masked data
    input  wire logic       clr_hit,
    input  wire logic       set_hit,
    input  wire logic [7:0] wr_bits,
    // State and misuse flags
    output var  logic [7:0] prot_reg,
    output var  logic       dbl_set,
    output var  logic       dbl_clr
);
    import pwg_pkg::*;

    logic [7:0] bits;
    logic [7:0] prot_next;

    assign bits      = wr_bits & VALID_MASK;
    assign prot_next = set_hit ? (prot_reg | bits) :
                       clr_hit ? (prot_reg & ~bits) :
                       prot_reg;
    assign dbl_set   = set_hit & (|(bits & prot_reg));
    assign dbl_clr   = clr_hit & (|(bits & ~prot_reg));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_reg <= RESET_VAL;
        end else begin
            prot_reg <= prot_next;
        end
    end

endmodule : pwg_protect_group

`default_nettype wire

/* rtl/pwg_write_gate.sv */
// Gates peripheral write requests with the protect state and flags refused writes.
`timescale 1ns/100ps
`default_nettype none

module pwg_write_gate (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Protect state and peripheral write requests
    input  wire logic [7:0] protect,
    input  wire logic [7:0] wr_req,
    // Gated writes and access error
    output var  logic [7:0] wr_grant,
    output var  logic       wr_err_reg
);
    import pwg_pkg::*;

    logic blocked;

    assign wr_grant = wr_req & ~protect;
    assign blocked  = |(wr_req & protect);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_err_reg <= 1'b0;
        end else begin
            wr_err_reg <= blocked;
        end
    end

    blocked_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_req & protect) != 8'h00 |-> wr_grant == (wr_req & ~protect) ##1 wr_err_reg)
        else $error("Blocked write did not raise the access error.");

endmodule : pwg_write_gate

`default_nettype wire

/* verif/pwg_periph_model.sv */
// Peripheral write requester standing on the guarded side of the block.
`timescale 1ns/100ps
`default_nettype none

module pwg_periph_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Bench command
    input  wire logic       fire,
    input  wire logic [7:0] bits_g0,
    input  wire logic [7:0] bits_g1,
    // Write attempts toward the guard
    output var  logic [7:0] req_g0,
    output var  logic [7:0] req_g1
);
    // An attempt lasts one cycle, as a single peripheral bus write would.
    always_ff @(posedge aclk) begin
        if (!aresetn || !fire) begin
            req_g0 <= 8'h00;
            req_g1 <= 8'h00;
        end else begin
            req_g0 <= bits_g0;
            req_g1 <= bits_g1;
        end
    end
endmodule : pwg_periph_model

`default_nettype wire

/* verif/tb_pwg_access_guard.sv */
// Self-checking bench of the peripheral write guard register block.
`timescale 1ns/100ps
`default_nettype none
`include "pwg_cfg.svh"

module tb_pwg_access_guard;
    import pwg_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [7:0]  bits0 = 8'h00, bits1 = 8'h00, req0, req1, gnt0, gnt1;
    logic [7:0]  p0 = `PWG_G0_RESET, p1 = `PWG_G1_RESET;
    logic [2:0]  sts = 3'h0, msk = 3'h0;
    logic [1:0]  bresp, rresp, e_pend;
    logic        awready, wready, bvalid, arready, rvalid, err0, err1, irq, e_chk = 1'b0;
    logic [15:0] g;
    logic [11:0] a;
    pwg_grp0_s   g0p;
    pwg_grp1_s   g1p;
    logic [1:0]  exp_b[$], exp_rr[$];
    logic [31:0] exp_rd[$];
    logic [15:0] exp_g[$];
    int          err_count = 0, cmp_count = 0;

    always #2.5 aclk = ~aclk;

    pwg_access_guard pwg_access_guard_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .periph_wr_req_g0(req0), .periph_wr_req_g1(req1),
        .periph_wr_grant_g0(gnt0), .periph_wr_grant_g1(gnt1),
        .periph_wr_err_g0(err0), .periph_wr_err_g1(err1),
        .grp0_protect(g0p), .grp1_protect(g1p), .irq(irq)
    );

    pwg_periph_model pwg_periph_model_inst (
        .aclk(aclk), .aresetn(aresetn), .fire(fire), .bits_g0(bits0),
        .bits_g1(bits1), .req_g0(req0), .req_g1(req1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t resp got %h exp %h", $time, got, exp);
        end
    endtask : cmp_resp

    // Every wait is bounded so a stuck handshake ends the run with a verdict.
    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100) begin
            err_count++;
            $display("FAIL t=%0t wait bound got %h exp %h", $time, 1'b0, 1'b1);
            test_done();
        end
    endtask : step

    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        int   n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        exp_b.push_back(r);
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            step(n);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do step(n); while (!bvalid);
    endtask : wr

    task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        exp_rd.push_back(d);
        exp_rr.push_back(r);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do step(n); while (!arready);
        arvalid <= 1'b0;
        do step(n); while (!rvalid);
    endtask : rd

    // Protect write with the expected answer and state worked out beforehand.
    task automatic pw(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        logic [7:0] b, p;
        logic [1:0] r;
        p = ad[8] ? p1 : p0;
        b = s[0] ? (d[7:0] & (ad[8] ? `PWG_G1_VALID : `PWG_G0_VALID)) : 8'h00;
        r = `PWG_RESP_OKAY;
        if (ad[2] && |(b & p)) begin
            r = `PWG_RESP_SLVERR;
            sts[0] = 1'b1;
        end
        if (!ad[2] && |(b & ~p)) begin
            r = `PWG_RESP_SLVERR;
            sts[1] = 1'b1;
        end
        p = ad[2] ? (p | b) : (p & ~b);
        if (ad[8]) p1 = p;
        else p0 = p;
        wr(ad, d, s, r);
    endtask : pw

    task automatic rv(input logic gs);
        rd({3'h0, gs, 8'h00}, {24'h0, gs ? p1 : p0}, `PWG_RESP_OKAY);
        rd({3'h0, gs, 8'h04}, {24'h0, gs ? p1 : p0}, `PWG_RESP_OKAY);
        cmp_val({26'h0, g0p}, {26'h0, p0[6:1]});
        cmp_val({28'h0, g1p}, {28'h0, p1[6], p1[3:1]});
    endtask : rv

    task automatic pr(input logic [7:0] b0, input logic [7:0] b1);
        exp_g.push_back({b1 & ~p1, b0 & ~p0});
        if (|(b0 & p0) || |(b1 & p1)) sts[2] = 1'b1;
        bits0 <= b0;
        bits1 <= b1;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : pr

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (e_chk) cmp_val({30'h0, err1, err0}, {30'h0, e_pend});
        e_chk = 1'b0;
        if (aresetn && bvalid && bready) cmp_resp(bresp, exp_b.pop_front());
        if (aresetn && rvalid && rready) begin
            cmp_resp(rresp, exp_rr.pop_front());
            cmp_val(rdata, exp_rd.pop_front());
        end
        if (aresetn && (req0 | req1) != 8'h00) begin
            g = exp_g.pop_front();
            cmp_val({16'h0, gnt1, gnt0}, {16'h0, g});
            e_pend = {|(req1 & ~g[15:8]), |(req0 & ~g[7:0])};
            e_chk = 1'b1;
        end
    end

    initial begin
        void'($urandom(32'hF82718B1));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rv(1'b0);
        rv(1'b1);
        rd(`PWG_STAT_ADDR, 32'h0, `PWG_RESP_OKAY);
        $display("reset test done");
        pw(12'h004, 32'hFFFF_FFFF, 4'hF);
        rv(1'b0);
        pw(12'h104, 32'h0000_0002, 4'h1);
        pw(12'h000, 32'h0000_00FF, 4'hE);
        pw(12'h000, 32'h0000_0000, 4'hF);
        for (int i = 1; i < 7; i++) begin
            pw(12'h000, 32'h1 << i, 4'h1);
            rv(1'b0);
        end
        pw(12'h000, 32'h0000_0002, 4'h1);
        $display("set and clear test done");
        msk = 3'h7;
        wr(`PWG_MASK_ADDR, 32'h7, 4'hF, `PWG_RESP_OKAY);
        cmp_val({31'h0, irq}, {31'h0, |(sts & msk)});
        rd(`PWG_STAT_ADDR, {29'h0, sts}, `PWG_RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            a = {3'h0, 1'($urandom), 5'h0, 1'($urandom), 2'h0};
            pw(a, $urandom, 4'($urandom));
            rv(a[8]);
            pr(8'($urandom) | 8'h01, 8'($urandom));
            cmp_val({31'h0, irq}, {31'h0, |(sts & msk)});
        end
        rd(`PWG_STAT_ADDR, {29'h0, sts}, `PWG_RESP_OKAY);
        msk = 3'h0;
        wr(`PWG_MASK_ADDR, 32'h0, 4'hF, `PWG_RESP_OKAY);
        cmp_val({31'h0, irq}, 32'h0);
        sts = 3'h0;
        wr(`PWG_STAT_ADDR, 32'h7, 4'hF, `PWG_RESP_OKAY);
        rd(`PWG_STAT_ADDR, 32'h0, `PWG_RESP_OKAY);
        $display("random and interrupt test done");
        wr(12'h300, 32'hFFFF_FFFF, 4'hF, `PWG_RESP_DECERR);
        rd(12'h008, 32'h0, `PWG_RESP_DECERR);
        rv(1'b1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        p0 = `PWG_G0_RESET;
        p1 = `PWG_G1_RESET;
        @(posedge aclk);
        rv(1'b0);
        rv(1'b1);
        $display("unmapped and reset test done");
        test_done();
    end
endmodule : tb_pwg_access_guard

`default_nettype wire
